// file: hw/llpm_mapper.sv
// line link node manager and process word mapper with apb registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module llpm_mapper #(
  parameter int CYCLE_CLKS = llpm_pkg::BUS_CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [llpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [llpm_pkg::NODE_W-1:0] link_node_number_nv,
  input wire logic [7:0] comm_firmware_select_nv,
  output logic [llpm_pkg::NODE_W-1:0] link_node_number,
  output logic [7:0] comm_firmware_select,
  output logic [7:0] ip_last_octet,
  output logic sync_master,
  input wire logic sync_in,
  output logic sync_out,
  output logic tx_valid,
  output logic [llpm_pkg::SLOT_W-1:0] tx_index,
  output logic [llpm_pkg::WORD_W-1:0] tx_data,
  input wire logic rx_valid,
  input wire logic [llpm_pkg::NODE_W-1:0] rx_node,
  input wire logic [llpm_pkg::SLOT_W-1:0] rx_index,
  input wire logic [llpm_pkg::WORD_W-1:0] rx_data,
  output logic sender_missing_alarm,
  output logic alarm_report,
  output logic [llpm_pkg::NODE_W-1:0] alarm_node,
  output logic process_data_timeout_fault
);
  import llpm_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic boot_done_reg;
  logic [NODE_W-1:0] act_node_reg;
  logic [7:0] act_fw_reg;
  logic link_en;
  logic ucm_reg;
  logic [1:0] eval_reg;
  logic [NODE_W-1:0] part_reg;
  logic [MAP_W-1:0] send_map_reg [SLOTS];
  logic [NODE_W-1:0] rx_src_reg [SLOTS];
  logic [MAP_W-1:0] rx_idx_reg [SLOTS];
  logic [WORD_W-1:0] rx_word_reg [SLOTS];
  logic ctrl_fault_reg;
  logic [$clog2(CYCLE_CLKS)-1:0] cyc_cnt_reg;
  logic tick_reg;
  logic tx_run_reg;
  logic [SLOT_W-1:0] tx_slot_reg;
  logic s1_valid_reg;
  logic s1_zero_reg;
  logic [SLOT_W-1:0] s1_index_reg;
  logic [WORD_W-1:0] mem_rdata;
  logic [MAP_W-1:0] cur_map;
  logic [MAX_NODES-1:0] heard_reg;
  logic [MAX_NODES-1:0] seen_reg;
  logic [MAX_NODES-1:0] missing_reg;
  logic [MAX_NODES-1:0] lost_now;
  logic [5:0] scan_ptr_reg;
  logic report_due_reg;
  logic apb_acc;
  logic apb_wr;
  logic [5:0] grp;
  logic [3:0] idx;
  logic [31:0] rd_mux;
  logic bad_addr;

  assign apb_acc = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign grp = paddr[11:6];
  assign idx = paddr[5:2];
  // link only with link firmware and a non-zero node number
  assign link_en = boot_done_reg && act_fw_reg == FW_LINK && act_node_reg != NODE_RESET;

  // --------------------------------------------------------------------
  // boot capture of non-volatile settings
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      boot_done_reg <= 1'b0;
      act_node_reg <= NODE_RESET;
      act_fw_reg <= FW_RESET;
    end else if (!boot_done_reg) begin
      boot_done_reg <= 1'b1;
      act_node_reg <= link_node_number_nv;
      act_fw_reg <= comm_firmware_select_nv;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_master <= 1'b0;
      ip_last_octet <= 8'h00;
    end else begin
      sync_master <= link_en && act_node_reg == SYNC_MASTER_NODE;
      ip_last_octet <= {1'b0, act_node_reg};
    end
  end

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ucm_reg <= 1'b0;
      eval_reg <= EVAL_RESET;
      part_reg <= PART_RESET;
      link_node_number <= NODE_RESET;
      comm_firmware_select <= FW_RESET;
    end else if (apb_wr && grp == GRP_MISC) begin
      if (idx == IDX_CONFIG) begin
        ucm_reg <= pwdata[CFG_UCM_BIT];
        eval_reg <= pwdata[CFG_EVAL_LSB +: 2];
        // pending values only; they reach the link after the next power cycle
        if (ucm_reg) begin
          link_node_number <= pwdata[CFG_NODE_LSB +: NODE_W];
          comm_firmware_select <= pwdata[CFG_FW_LSB +: 8];
        end
      end
      if (idx == IDX_PARTICIPANTS) begin
        part_reg <= pwdata[NODE_W-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      logic hit;
      // live routing, no restart needed
      assign hit = rx_valid && link_en && rx_idx_reg[g] != '0 && rx_node == rx_src_reg[g]
        && rx_node != act_node_reg && {1'b0, rx_index} == rx_idx_reg[g] - 5'h01;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          send_map_reg[g] <= '0;
          rx_src_reg[g] <= '0;
          rx_idx_reg[g] <= '0;
        end else if (apb_wr && idx == 4'(g)) begin
          if (grp == GRP_SEND_MAP) begin
            send_map_reg[g] <= pwdata[MAP_W-1:0];
          end
          if (grp == GRP_RX_SEL) begin
            rx_src_reg[g] <= pwdata[RXS_NODE_LSB +: NODE_W];
            rx_idx_reg[g] <= pwdata[RXS_IDX_LSB +: MAP_W];
          end
        end
      end
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          rx_word_reg[g] <= '0;
        end else if (hit) begin
          rx_word_reg[g] <= rx_data;
        end
      end
    end
  endgenerate

  // control word check on receive slot 0
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_fault_reg <= 1'b0;
    end else begin
      ctrl_fault_reg <= link_en && eval_reg != EVAL_OFF && rx_idx_reg[0] != '0
        && !rx_word_reg[0][CTRL_BIT];
    end
  end

  // --------------------------------------------------------------------
  // bus cycle timing
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cyc_cnt_reg <= '0;
      tick_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      sync_out <= 1'b0;
      if (!link_en) begin
        cyc_cnt_reg <= '0;
      end else if (act_node_reg == SYNC_MASTER_NODE) begin
        if (cyc_cnt_reg == $bits(cyc_cnt_reg)'(CYCLE_CLKS - 1)) begin
          cyc_cnt_reg <= '0;
          tick_reg <= 1'b1;
          sync_out <= 1'b1;
        end else begin
          cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
        end
      end else begin
        tick_reg <= sync_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // send telegram
  // --------------------------------------------------------------------
  assign cur_map = send_map_reg[tx_slot_reg];

  llpm_word_mem #(
    .WIDTH(WORD_W),
    .DEPTH(SLOTS),
    .AW(SLOT_W)
  ) u_send_src (
    .clk(core_clk),
    .wr_en(apb_wr && grp == GRP_SEND_SRC),
    .wr_addr(idx),
    .wr_data(pwdata[WORD_W-1:0]),
    .rd_addr(cur_map[SLOT_W-1:0] - 4'h1),
    .rd_data(mem_rdata)
  );

  // a tick during a running telegram restarts it; the cycle is far longer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_run_reg <= 1'b0;
      tx_slot_reg <= '0;
      s1_valid_reg <= 1'b0;
      s1_zero_reg <= 1'b0;
      s1_index_reg <= '0;
    end else begin
      s1_valid_reg <= tx_run_reg;
      s1_index_reg <= tx_slot_reg;
      s1_zero_reg <= cur_map == '0 || cur_map > 5'(SLOTS);
      if (tick_reg && link_en) begin
        tx_run_reg <= 1'b1;
        tx_slot_reg <= '0;
      end else if (tx_run_reg) begin
        tx_slot_reg <= tx_slot_reg + 1'b1;
        if (tx_slot_reg == 4'(SLOTS - 1)) begin
          tx_run_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_index <= '0;
      tx_data <= '0;
    end else begin
      tx_valid <= s1_valid_reg && link_en;
      tx_index <= s1_index_reg;
      tx_data <= s1_zero_reg ? '0 : mem_rdata;
    end
  end

  // --------------------------------------------------------------------
  // sender supervision per node
  // --------------------------------------------------------------------
  generate
    for (g = 0; g < MAX_NODES; g++) begin : g_node
      logic [MISS_W-1:0] miss_reg;
      logic active;
      assign active = link_en && 7'(g + 1) <= part_reg && 7'(g + 1) != act_node_reg;
      assign lost_now[g] = active && tick_reg && !heard_reg[g] && seen_reg[g]
        && miss_reg == 3'(MISS_LIMIT - 1);
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          heard_reg[g] <= 1'b0;
          seen_reg[g] <= 1'b0;
          missing_reg[g] <= 1'b0;
          miss_reg <= '0;
        end else if (!active) begin
          heard_reg[g] <= 1'b0;
          seen_reg[g] <= 1'b0;
          missing_reg[g] <= 1'b0;
          miss_reg <= '0;
        end else begin
          // a word in the tick cycle counts for the next cycle
          heard_reg[g] <= (rx_valid && rx_node == 7'(g + 1)) || (heard_reg[g] && !tick_reg);
          if (tick_reg) begin
            if (heard_reg[g]) begin
              miss_reg <= '0;
              seen_reg[g] <= 1'b1;
              missing_reg[g] <= 1'b0;
            end else if (miss_reg == 3'(MISS_LIMIT - 1)) begin
              missing_reg[g] <= 1'b1;
            end else begin
              miss_reg <= miss_reg + 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // one report per bus cycle, rotating over missing nodes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_ptr_reg <= '0;
      report_due_reg <= 1'b0;
      alarm_report <= 1'b0;
      alarm_node <= NODE_RESET;
      sender_missing_alarm <= 1'b0;
    end else begin
      scan_ptr_reg <= scan_ptr_reg + 1'b1;
      alarm_report <= 1'b0;
      sender_missing_alarm <= |missing_reg;
      if (tick_reg) begin
        report_due_reg <= 1'b1;
      end else if (report_due_reg && missing_reg[scan_ptr_reg]) begin
        report_due_reg <= 1'b0;
        alarm_report <= 1'b1;
        alarm_node <= {1'b0, scan_ptr_reg} + 7'h01;
      end
      if (!(|missing_reg)) begin
        alarm_node <= NODE_RESET;
      end
    end
  end

  // sticky; a new loss in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      process_data_timeout_fault <= 1'b0;
    end else if (|lost_now) begin
      process_data_timeout_fault <= 1'b1;
    end else if (apb_wr && grp == GRP_MISC && idx == IDX_FAULT_CLR && pwdata[0]) begin
      process_data_timeout_fault <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // apb read and answer
  // --------------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    bad_addr = 1'b0;
    case (grp)
      GRP_MISC: begin
        case (idx)
          IDX_CONFIG: begin
            rd_mux[CFG_NODE_LSB +: NODE_W] = link_node_number;
            rd_mux[CFG_FW_LSB +: 8] = comm_firmware_select;
            rd_mux[CFG_UCM_BIT] = ucm_reg;
            rd_mux[CFG_EVAL_LSB +: 2] = eval_reg;
          end
          IDX_STATUS: begin
            rd_mux[ST_NODE_LSB +: NODE_W] = act_node_reg;
            rd_mux[ST_MASTER_BIT] = sync_master;
            rd_mux[ST_LINK_BIT] = link_en;
            rd_mux[ST_CTRL_BIT] = ctrl_fault_reg;
            rd_mux[ST_ALARM_BIT] = sender_missing_alarm;
            rd_mux[ST_TIMEOUT_BIT] = process_data_timeout_fault;
            rd_mux[ST_ALNODE_LSB +: NODE_W] = alarm_node;
          end
          IDX_FAULT_CLR: rd_mux = '0;
          IDX_PARTICIPANTS: rd_mux[NODE_W-1:0] = part_reg;
          default: bad_addr = 1'b1;
        endcase
      end
      GRP_SEND_MAP: rd_mux[MAP_W-1:0] = send_map_reg[idx];
      GRP_SEND_SRC: rd_mux = '0;
      GRP_RX_SEL: begin
        rd_mux[RXS_NODE_LSB +: NODE_W] = rx_src_reg[idx];
        rd_mux[RXS_IDX_LSB +: MAP_W] = rx_idx_reg[idx];
      end
      GRP_RX_WORD: rd_mux[WORD_W-1:0] = rx_word_reg[idx];
      GRP_RX_DWORD: begin
        if (idx == 4'(SLOTS - 1)) begin
          bad_addr = 1'b1;
        end else begin
          rd_mux = {rx_word_reg[idx], rx_word_reg[idx + 4'h1]};
        end
      end
      default: bad_addr = 1'b1;
    endcase
    if (paddr[1:0] != 2'h0) begin
      bad_addr = 1'b1;
    end
  end

  // fixed one wait state keeps read timing simple
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc && bad_addr;
      if (apb_acc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule // llpm_mapper

// file: hw/llpm_word_mem.sv
// small word memory with registered read data
`timescale 1ns/1ps
module llpm_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // no reset: contents are defined by software before the link runs
  always_ff @(posedge clk) begin
    rd_data <= mem_reg[rd_addr];
  end
endmodule // llpm_word_mem

// file: pkg/llpm_pkg.sv
// constants, register map and field layout of the line link process word mapper
package llpm_pkg;
  localparam int NODE_W = 7;
  localparam int WORD_W = 16;
  localparam int SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int MAP_W = 5;
  localparam int MAX_NODES = 64;
  localparam int ADDR_W = 12;
  localparam int MISS_W = 3;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int BUS_CYCLE_US = 1000;
  localparam int BUS_CYCLE_CLKS = (CLK_HZ / 1000000) * BUS_CYCLE_US;
  localparam int MISS_LIMIT = 3;
  // --------------------------------------------------------------------
  // codes
  // --------------------------------------------------------------------
  localparam logic [7:0] FW_LINK = 8'h03;
  localparam logic [7:0] FW_RESET = 8'h01;
  localparam logic [1:0] EVAL_OFF = 2'h2;
  localparam int CTRL_BIT = 10;
  localparam logic [NODE_W-1:0] SYNC_MASTER_NODE = 7'h01;
  // --------------------------------------------------------------------
  // register map: group in paddr[11:6], entry in paddr[5:2]
  // --------------------------------------------------------------------
  localparam logic [5:0] GRP_MISC = 6'h00;
  localparam logic [5:0] GRP_SEND_MAP = 6'h01;
  localparam logic [5:0] GRP_SEND_SRC = 6'h02;
  localparam logic [5:0] GRP_RX_SEL = 6'h03;
  localparam logic [5:0] GRP_RX_WORD = 6'h04;
  localparam logic [5:0] GRP_RX_DWORD = 6'h05;
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_FAULT_CLR = 4'h2;
  localparam logic [3:0] IDX_PARTICIPANTS = 4'h3;
  // config fields
  localparam int CFG_NODE_LSB = 0;
  localparam int CFG_FW_LSB = 8;
  localparam int CFG_UCM_BIT = 16;
  localparam int CFG_EVAL_LSB = 18;
  // status fields
  localparam int ST_NODE_LSB = 0;
  localparam int ST_MASTER_BIT = 7;
  localparam int ST_LINK_BIT = 8;
  localparam int ST_CTRL_BIT = 9;
  localparam int ST_ALARM_BIT = 10;
  localparam int ST_TIMEOUT_BIT = 11;
  localparam int ST_ALNODE_LSB = 16;
  // receive select fields
  localparam int RXS_NODE_LSB = 0;
  localparam int RXS_IDX_LSB = 8;
  // reset values
  localparam logic [NODE_W-1:0] NODE_RESET = 7'h00;
  localparam logic [1:0] EVAL_RESET = 2'h0;
  localparam logic [NODE_W-1:0] PART_RESET = 7'h00;
endpackage

// file: testbench/llpm_checker.sv
// port assertions for the line link process word mapper
`timescale 1ns/1ps
module llpm_checker #(
  parameter int CYCLE_CLKS = llpm_pkg::BUS_CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pwrite,
  input wire logic [llpm_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [7:0] ip_last_octet,
  input wire logic sync_master,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic tx_valid,
  input wire logic [llpm_pkg::SLOT_W-1:0] tx_index,
  input wire logic sender_missing_alarm,
  input wire logic alarm_report,
  input wire logic [llpm_pkg::NODE_W-1:0] alarm_node,
  input wire logic process_data_timeout_fault
);
  import llpm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int gap_reg;
  logic seen_reg;
  // first tick after reset has no reference, hence seen_reg
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_reg <= 0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= sync_out ? 0 : gap_reg + 1;
      seen_reg <= seen_reg | sync_out;
    end
  end
  a_tick_period: assert property (sync_out && seen_reg |-> gap_reg == CYCLE_CLKS - 1)
    else $error("bus cycle tick spacing wrong");
  a_tick_master: assert property (sync_out |-> sync_master)
    else $error("tick from a follower");
  a_master_ip: assert property (sync_master |-> ip_last_octet == 8'h01)
    else $error("master role without node one");
  a_ip_fixed: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> $stable(ip_last_octet))
    else $error("address octet changed in run");
  a_off_zero: assert property (ip_last_octet == 8'h00 |-> !tx_valid && !sync_master)
    else $error("link active at node zero");
  a_frame_len: assert property ($rose(tx_valid) |-> tx_index == 4'h0 ##15 tx_valid && tx_index == 4'hF ##1 !tx_valid)
    else $error("telegram not sixteen words");
  a_slot_step: assert property (tx_valid && $past(tx_valid) |-> tx_index == $past(tx_index) + 4'h1)
    else $error("send slot order broken");
  a_follow_sync: assert property ($rose(tx_valid) && !sync_master |-> $past(sync_in, 4))
    else $error("follower sent off its tick");
  a_report_node: assert property (alarm_report |-> sender_missing_alarm && alarm_node != 7'h00)
    else $error("report without missing node");
  a_fault_clear: assert property ($fell(process_data_timeout_fault) |-> $past(pready && pwrite
    && paddr == {GRP_MISC, IDX_FAULT_CLR, 2'b00}))
    else $error("timeout fault dropped by itself");
  cover property (alarm_report);
  cover property ($rose(process_data_timeout_fault));
  cover property ($rose(tx_valid) && !sync_master);
endmodule // llpm_checker

// file: testbench/llpm_peer_model.sv
// behavioural model of neighbour nodes 2 and 3 on the line link
`timescale 1ns/1ps
module llpm_peer_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [3:0] alive,
  input wire logic [15:0] base,
  output logic rx_valid,
  output logic [llpm_pkg::NODE_W-1:0] rx_node,
  output logic [llpm_pkg::SLOT_W-1:0] rx_index,
  output logic [llpm_pkg::WORD_W-1:0] rx_data
);
  import llpm_pkg::*;
  logic [5:0] pos_reg;
  initial begin
    rx_valid = 1'b0;
    rx_node = 7'h00;
    rx_index = 4'h0;
    rx_data = 16'h0000;
  end
  // bit 4 picks the node, bits 3:0 the word
  always @(posedge core_clk) begin
    if (!rst_n) pos_reg <= 6'h20;
    else if (tick) pos_reg <= 6'h00;
    else if (!pos_reg[5]) pos_reg <= pos_reg + 6'h01;
  end
  // idle lines toggle so stale data is never mistaken for fresh
  always @(posedge core_clk) begin
    if (rst_n && !pos_reg[5] && alive[{1'b1, pos_reg[4]}]) begin
      rx_valid <= 1'b1;
      rx_node <= {6'h01, pos_reg[4]};
      rx_index <= pos_reg[3:0];
      rx_data <= base ^ {8'h00, 3'h1, pos_reg[4:0]};
    end else begin
      rx_valid <= 1'b0;
      rx_node <= ~rx_node;
      rx_index <= ~rx_index;
      rx_data <= ~rx_data;
    end
  end
endmodule // llpm_peer_model

// file: testbench/tb_top.sv
// self-checking testbench for the line link process word mapper
`timescale 1ns/1ps
module tb_top;
  import llpm_pkg::*;
  localparam int P = 40;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sync_master, sync_out, tx_valid, rx_valid;
  logic sync_in = 1'b0, sender_missing_alarm, alarm_report, process_data_timeout_fault;
  logic [6:0] link_node_number_nv = 7'h00, link_node_number, rx_node, alarm_node;
  logic [7:0] comm_firmware_select_nv = 8'h00, comm_firmware_select, ip_last_octet;
  logic [3:0] tx_index, rx_index, alive = 4'hC;
  logic [15:0] tx_data, rx_data, base = 16'h0400, o5, txw [16], src [16];
  logic [4:0] map [16], sel_i [16];
  logic [6:0] sel_n [16];
  logic [7:0] rep = 8'h00;
  int seed = 32'hAB39, n_fail = 0, n_compared = 0, n_tx = 0, n_sync = 0;
  always #50 core_clk = ~core_clk;
  llpm_mapper #(.CYCLE_CLKS(P)) llpm_mapper_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link_node_number_nv, .comm_firmware_select_nv,
    .link_node_number, .comm_firmware_select, .ip_last_octet, .sync_master, .sync_in, .sync_out,
    .tx_valid, .tx_index, .tx_data, .rx_valid, .rx_node, .rx_index, .rx_data, .sender_missing_alarm,
    .alarm_report, .alarm_node, .process_data_timeout_fault);
  llpm_peer_model llpm_peer_model_i (.core_clk, .rst_n, .tick(sync_out | sync_in), .alive, .base,
    .rx_valid, .rx_node, .rx_index, .rx_data);
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1) begin
      txw[tx_index] = tx_data;
      n_tx++;
    end
    if (sync_out === 1'b1) n_sync++;
    if (alarm_report === 1'b1) rep[alarm_node[2:0]] = 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one idle edge after each transfer keeps drivers from double assignment
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit; the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [11:0] ad(input logic [5:0] g, input logic [3:0] i);
    return {g, i, 2'b00};
  endfunction
  function automatic logic [15:0] pd(input logic [6:0] n, input logic [3:0] i);
    return base ^ {8'h00, n[3:0], i};
  endfunction
  function automatic logic [15:0] exp_tx(input logic [4:0] m);
    return (m == 5'h00 || m > 5'h10) ? 16'h0000 : src[m - 5'h01];
  endfunction
  task automatic boot(input logic [6:0] nd, input logic [7:0] fw);
    rst_n <= 1'b0;
    link_node_number_nv <= nd;
    comm_firmware_select_nv <= fw;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n * P) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    end_sim;
  end
  initial begin
    boot(7'h01, FW_LINK);
    chk("ip", 32'(ip_last_octet), 32'h1);
    apb(1'b0, ad(GRP_MISC, IDX_STATUS), 32'h0);
    chk("status", 32'(rd[8:0]), 32'h181);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'b1, 12'h000, 32'h0305);
    chk("locked node", 32'(link_node_number), 32'h0);
    apb(1'b1, 12'h000, 32'h10000);
    apb(1'b1, 12'h000, 32'h10305);
    apb(1'b1, 12'h000, 32'h0305);
    chk("pending node", 32'({comm_firmware_select, link_node_number}), 32'h185);
    chk("ip kept", 32'(ip_last_octet), 32'h1);
    // ---------------------------------------------------------------
    // send slots, with unused, double word and out of range maps
    // ---------------------------------------------------------------
    for (int i = 0; i < 16; i++) begin
      src[i] = 16'($random(seed));
      map[i] = i < 5 ? 5'(i * 2 % 19) : 5'($random(seed));
      apb(1'b1, ad(GRP_SEND_SRC, 4'(i)), 32'(src[i]));
      apb(1'b1, ad(GRP_SEND_MAP, 4'(i)), 32'(map[i]));
    end
    ticks(2);
    for (int i = 0; i < 16; i++) chk("tx word", 32'(txw[i]), 32'(exp_tx(map[i])));
    // ---------------------------------------------------------------
    // receive slots and control word
    // ---------------------------------------------------------------
    base = 16'($random(seed)) | 16'h0400;
    apb(1'b1, ad(GRP_MISC, IDX_PARTICIPANTS), 32'h3);
    for (int i = 0; i < 16; i++) begin
      sel_n[i] = i < 3 ? 7'(i > 0 ? 3 : 2) : 7'h02 + 7'($random(seed) & 1);
      sel_i[i] = i < 3 ? 5'(i > 0 ? i + 2 : 1) : 5'h01 + 5'($random(seed) & 15);
      apb(1'b1, ad(GRP_RX_SEL, 4'(i)), 32'({sel_i[i], 1'b0, sel_n[i]}));
    end
    ticks(2);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, ad(GRP_RX_WORD, 4'(i)), 32'h0);
      chk("rx word", rd, 32'(pd(sel_n[i], 4'(sel_i[i] - 5'h01))));
    end
    apb(1'b0, ad(GRP_RX_DWORD, 4'h1), 32'h0);
    chk("rx dword", rd, {pd(7'h03, 4'h2), pd(7'h03, 4'h3)});
    apb(1'b0, ad(GRP_RX_DWORD, 4'hF), 32'h0);
    chk("dword end", 32'(err), 32'h1);
    apb(1'b0, ad(GRP_MISC, IDX_STATUS), 32'h0);
    chk("ctrl ok", 32'(rd[10:9]), 32'h0);
    o5 = pd(sel_n[4], 4'(sel_i[4] - 5'h01));
    // new data only once slot 4 is switched off, so no fresh word can slip in
    apb(1'b1, ad(GRP_RX_SEL, 4'h4), 32'(sel_n[4]));
    base = 16'($random(seed)) & 16'hFBFF;
    ticks(2);
    apb(1'b0, ad(GRP_RX_WORD, 4'h4), 32'h0);
    chk("slot off", rd, 32'(o5));
    apb(1'b0, ad(GRP_RX_WORD, 4'h0), 32'h0);
    chk("rx new", rd, 32'(pd(7'h02, 4'h0)));
    apb(1'b0, ad(GRP_MISC, IDX_STATUS), 32'h0);
    chk("ctrl bad", 32'(rd[9]), 32'h1);
    apb(1'b1, 12'h000, 32'h80305);
    ticks(2);
    apb(1'b0, ad(GRP_MISC, IDX_STATUS), 32'h0);
    chk("ctrl masked", 32'(rd[9]), 32'h0);
    // ---------------------------------------------------------------
    // sender supervision: drop 3, then 2, then repair both
    // ---------------------------------------------------------------
    alive = 4'h4;
    ticks(6);
    chk("alarm", 32'({sender_missing_alarm, alarm_node}), 32'h83);
    chk("fault", 32'(process_data_timeout_fault), 32'h1);
    alive = 4'h0;
    ticks(6);
    chk("reported", 32'(rep[3:2]), 32'h3);
    alive = 4'hC;
    ticks(3);
    chk("withdrawn", 32'({sender_missing_alarm, alarm_node}), 32'h0);
    apb(1'b1, ad(GRP_MISC, IDX_FAULT_CLR), 32'h1);
    chk("fault clr", 32'(process_data_timeout_fault), 32'h0);
    // ---------------------------------------------------------------
    // follower node 2, then link off by node 0 and by firmware
    // ---------------------------------------------------------------
    boot(7'h02, FW_LINK);
    base = ~base;
    apb(1'b1, ad(GRP_RX_SEL, 4'h5), 32'h0102);
    n_tx = 0;
    n_sync = 0;
    repeat (3) begin
      sync_in <= 1'b1;
      @(posedge core_clk);
      sync_in <= 1'b0;
      ticks(1);
    end
    chk("follower", 32'({sync_master, ip_last_octet}), 32'h2);
    chk("follower tx", 32'(n_tx + n_sync * 100), 32'd48);
    apb(1'b0, ad(GRP_RX_WORD, 4'h5), 32'h0);
    // reset cleared the slot; a word from node 2 would show here
    chk("own refused", rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      boot(7'(k), k ? FW_RESET : FW_LINK);
      n_tx = 0;
      sync_in <= 1'b1;
      @(posedge core_clk);
      sync_in <= 1'b0;
      ticks(3);
      chk("link off", 32'(n_tx + n_sync + sync_master), 32'h0);
    end
    end_sim;
  end
endmodule // tb_top
bind llpm_mapper llpm_checker #(.CYCLE_CLKS(CYCLE_CLKS)) llpm_checker_i (.core_clk, .rst_n, .pwrite,
  .paddr, .pready, .ip_last_octet, .sync_master, .sync_in, .sync_out, .tx_valid, .tx_index,
  .sender_missing_alarm, .alarm_report, .alarm_node, .process_data_timeout_fault);
